// ### core/psp_pkg.sv
// shared constants for the parallel slave port and its external master
package psp_pkg;
    localparam int DATA_W = 8;
    // device-side cpu register indices
    localparam logic [2:0] REG_PIN_DATA  = 3'h0;
    localparam logic [2:0] REG_OUT_LATCH = 3'h1;
    localparam logic [2:0] REG_DIR_D     = 3'h2;
    localparam logic [2:0] REG_DIR_E     = 3'h3;
    localparam logic [2:0] REG_CONTROL   = 3'h4;
    localparam logic [2:0] REG_IRQ_FLAG  = 3'h5;
    localparam logic [2:0] REG_IRQ_MASK  = 3'h6;
    // control register fields
    localparam int BIT_INPUT_FULL  = 7;
    localparam int BIT_OUTPUT_FULL = 6;
    localparam int BIT_OVERFLOW    = 5;
    localparam int BIT_MODE        = 4;
    // irq flag register fields
    localparam int IRQ_SLAVE_PORT = 7;
    localparam logic [7:0] DIR_RESET  = 8'hFF;
    localparam logic [2:0] DIR_E_NEED = 3'h7;
    // host-side command register indices
    localparam logic [1:0] HREG_DATA   = 2'h0;
    localparam logic [1:0] HREG_CMD    = 2'h1;
    localparam logic [1:0] HREG_STATUS = 2'h2;
    localparam int HCMD_WRITE = 0;
    localparam int HCMD_READ  = 1;
    // strobe low time in clk cycles, long enough to pass the sync plus edge logic
    localparam int STROBE_NS     = 80;
    localparam int CLK_NS        = 10;
    localparam int STROBE_CYCLES = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {
        PSP_IDLE   = 2'b00,
        PSP_ASSERT = 2'b01,
        PSP_HOLD   = 2'b11,
        PSP_DONE   = 2'b10
    } psp_host_e;
endpackage : psp_pkg

// ### core/psp_bus_if.sv
// pin-level link between an external master and the slave port
`timescale 1ns/1ps
`default_nettype none
interface psp_bus_if;
    logic       chipSelN;
    logic       readN;
    logic       writeN;
    logic [7:0] hostData;
    logic       hostDataOe;
    logic [7:0] portData;
    logic       portDataOe;
    logic [7:0] busData;
    assign busData = portDataOe ? portData : (hostDataOe ? hostData : 8'h00);
    modport device (
        input  chipSelN, readN, writeN, busData,
        output portData, portDataOe
    );
    modport host (
        input  busData,
        output chipSelN, readN, writeN, hostData, hostDataOe
    );
endinterface : psp_bus_if
`default_nettype wire

// ### core/psp_device.sv
// slave port end: cpu registers, pin sync, external read and write handling
`timescale 1ns/1ps
`default_nettype none
module psp_device (
    input  wire logic       clk,
    input  wire logic       rst,
    psp_bus_if.device       bus,
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    output logic            irq,
    output logic      [7:0] gpioOut,
    output logic      [7:0] gpioOe
);
    logic [7:0] outLatch;
    logic [7:0] inLatch;
    logic [7:0] dirD;
    logic [7:0] dirE;
    logic       modeSel;
    logic       inputFull;
    logic       outputFull;
    logic       overflow;
    logic       irqFlag;
    logic       irqMask;
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic       wrActive;
    logic       rdActive;
    logic [7:0] dataPipe;
    logic [7:0] dataSync;
    logic       slaveOn;
    logic       wrSel;
    logic       rdSel;
    logic       wrEnd;
    logic       rdStart;
    logic       rdEnd;
    logic       cpuWr;
    logic       cpuRd;

    // pins {cs, wr, rd}, two flops each; only syncB is looked at
    always_ff @(posedge clk) begin
        if (rst) begin
            syncA <= 3'h7;
            syncB <= 3'h7;
        end else begin
            syncA <= {bus.chipSelN, bus.writeN, bus.readN};
            syncB <= syncA;
        end
    end

    // port data takes the same two flops as the strobes, so a byte sampled
    // while the synced strobe is low was on the pins while the real one was
    always_ff @(posedge clk) begin
        if (rst) begin
            dataPipe <= 8'h00;
            dataSync <= 8'h00;
        end else begin
            dataPipe <= bus.busData;
            dataSync <= dataPipe;
        end
    end

    // port e pins act as strobes only while their directions are inputs
    assign slaveOn = modeSel && (dirE[2:0] == psp_pkg::DIR_E_NEED);
    assign wrSel   = slaveOn && !syncB[2] && !syncB[1];
    assign rdSel   = slaveOn && !syncB[2] && !syncB[0];
    assign wrEnd   = wrActive && !wrSel;
    assign rdStart = rdSel && !rdActive;
    assign rdEnd   = rdActive && !rdSel;
    assign cpuWr   = regWrite && regAddr == psp_pkg::REG_OUT_LATCH;
    assign cpuRd   = regRead && regAddr == psp_pkg::REG_PIN_DATA;

    always_ff @(posedge clk) begin
        if (rst) begin
            wrActive <= 1'b0;
            rdActive <= 1'b0;
            inLatch  <= 8'h00;
        end else begin
            wrActive <= wrSel;
            rdActive <= rdSel;
            // last aligned sample inside the strobe is the byte; the master
            // may drop its data right after the strobe rises
            if (wrSel) begin
                inLatch <= dataSync;
            end
        end
    end

    // cpu writable registers
    always_ff @(posedge clk) begin
        if (rst) begin
            outLatch <= 8'h00;
            dirD     <= psp_pkg::DIR_RESET;
            dirE     <= psp_pkg::DIR_RESET;
            modeSel  <= 1'b0;
            irqMask  <= 1'b0;
        end else if (regWrite) begin
            case (regAddr)
                psp_pkg::REG_PIN_DATA, psp_pkg::REG_OUT_LATCH: outLatch <= regWrData;
                psp_pkg::REG_DIR_D:  dirD    <= regWrData;
                psp_pkg::REG_DIR_E:  dirE    <= regWrData;
                psp_pkg::REG_CONTROL: modeSel <= regWrData[psp_pkg::BIT_MODE];
                psp_pkg::REG_IRQ_MASK: irqMask <= regWrData[psp_pkg::IRQ_SLAVE_PORT];
                default: ;
            endcase
        end
    end

    // status flags: hardware set wins over any clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            inputFull  <= 1'b0;
            outputFull <= 1'b0;
            overflow   <= 1'b0;
        end else begin
            if (wrEnd) begin
                inputFull <= 1'b1;
            end else if (cpuRd) begin
                inputFull <= 1'b0;
            end
            if (cpuWr || (regWrite && regAddr == psp_pkg::REG_PIN_DATA)) begin
                outputFull <= slaveOn && !rdActive;
            end else if (rdEnd) begin
                outputFull <= 1'b0;
            end
            if (wrEnd && inputFull && !cpuRd) begin
                overflow <= 1'b1;
            end else if (regWrite && regAddr == psp_pkg::REG_CONTROL
                         && !regWrData[psp_pkg::BIT_OVERFLOW]) begin
                overflow <= 1'b0;
            end
        end
    end

    // shared irq flag; a read of its register clears it
    always_ff @(posedge clk) begin
        if (rst) begin
            irqFlag <= 1'b0;
        end else if (wrEnd || rdEnd) begin
            irqFlag <= 1'b1;
        end else if (regRead && regAddr == psp_pkg::REG_IRQ_FLAG) begin
            irqFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= (irqFlag || wrEnd || rdEnd) && irqMask;
        end
    end

    // pin drive: slave read drives the latch, otherwise general io
    always_ff @(posedge clk) begin
        if (rst) begin
            bus.portData   <= 8'h00;
            bus.portDataOe <= 1'b0;
            gpioOut        <= 8'h00;
            gpioOe         <= 8'h00;
        end else begin
            bus.portData   <= (cpuWr || (regWrite && regAddr == psp_pkg::REG_PIN_DATA))
                              ? regWrData : outLatch;
            bus.portDataOe <= rdSel;
            gpioOut        <= outLatch;
            gpioOe         <= modeSel ? 8'h00 : ~dirD;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                psp_pkg::REG_PIN_DATA:  regRdData <= slaveOn ? inLatch : bus.busData;
                psp_pkg::REG_OUT_LATCH: regRdData <= outLatch;
                psp_pkg::REG_DIR_D:     regRdData <= dirD;
                psp_pkg::REG_DIR_E:     regRdData <= dirE;
                psp_pkg::REG_CONTROL:   regRdData <= {inputFull, outputFull, overflow,
                                                      modeSel, 4'h0};
                psp_pkg::REG_IRQ_FLAG:  regRdData <= {irqFlag, 7'h00};
                psp_pkg::REG_IRQ_MASK:  regRdData <= {irqMask, 7'h00};
                default:                regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end
endmodule : psp_device
`default_nettype wire

// ### core/psp_host.sv
// external master end: drives cs, rd, wr strobes and the data bus
`timescale 1ns/1ps
`default_nettype none
module psp_host #(
    parameter int STROBE_LEN = psp_pkg::STROBE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    psp_bus_if.host         bus,
    input  wire logic [1:0] cmdAddr,
    input  wire logic [7:0] cmdWrData,
    input  wire logic       cmdWrite,
    input  wire logic       cmdRead,
    output logic      [7:0] cmdRdData
);
    psp_pkg::psp_host_e state;
    logic [7:0] txData;
    logic [7:0] rxData;
    logic       isRead;
    logic       busy;
    logic       done;
    logic [7:0] count;
    logic       start;

    assign start = cmdWrite && cmdAddr == psp_pkg::HREG_CMD && state == psp_pkg::PSP_IDLE;

    always_ff @(posedge clk) begin
        if (rst) begin
            txData <= 8'h00;
        end else if (cmdWrite && cmdAddr == psp_pkg::HREG_DATA) begin
            txData <= cmdWrData;
        end
    end

    // strobes held long enough for the device sync; data held through the write
    always_ff @(posedge clk) begin
        if (rst) begin
            state          <= psp_pkg::PSP_IDLE;
            count          <= 8'h00;
            isRead         <= 1'b0;
            rxData         <= 8'h00;
            bus.chipSelN   <= 1'b1;
            bus.readN      <= 1'b1;
            bus.writeN     <= 1'b1;
            bus.hostData   <= 8'h00;
            bus.hostDataOe <= 1'b0;
        end else begin
            case (state)
                psp_pkg::PSP_IDLE: begin
                    if (start) begin
                        isRead         <= cmdWrData[psp_pkg::HCMD_READ];
                        bus.hostData   <= txData;
                        bus.hostDataOe <= !cmdWrData[psp_pkg::HCMD_READ];
                        bus.chipSelN   <= 1'b0;
                        count          <= 8'h00;
                        state          <= psp_pkg::PSP_ASSERT;
                    end
                end
                psp_pkg::PSP_ASSERT: begin
                    bus.readN  <= !isRead;
                    bus.writeN <= isRead;
                    state      <= psp_pkg::PSP_HOLD;
                end
                psp_pkg::PSP_HOLD: begin
                    count <= count + 8'h01;
                    if (count == 8'(STROBE_LEN - 1)) begin
                        rxData     <= bus.busData;
                        bus.readN  <= 1'b1;
                        bus.writeN <= 1'b1;
                        state      <= psp_pkg::PSP_DONE;
                    end
                end
                psp_pkg::PSP_DONE: begin
                    bus.chipSelN   <= 1'b1;
                    bus.hostDataOe <= 1'b0;
                    state          <= psp_pkg::PSP_IDLE;
                end
                default: state <= psp_pkg::PSP_IDLE;
            endcase
        end
    end

    assign busy = state != psp_pkg::PSP_IDLE;

    always_ff @(posedge clk) begin
        if (rst) begin
            done <= 1'b0;
        end else if (state == psp_pkg::PSP_DONE) begin
            done <= 1'b1;
        end else if (cmdRead && cmdAddr == psp_pkg::HREG_STATUS) begin
            done <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmdRdData <= 8'h00;
        end else if (cmdRead) begin
            case (cmdAddr)
                psp_pkg::HREG_DATA:   cmdRdData <= rxData;
                psp_pkg::HREG_STATUS: cmdRdData <= {6'h00, done, busy};
                default:              cmdRdData <= 8'h00;
            endcase
        end else begin
            cmdRdData <= 8'h00;
        end
    end
endmodule : psp_host
`default_nettype wire

// ### tb/psp_props.sv
// interface checks for the parallel slave port pin link
`timescale 1ns/1ps
`default_nettype none
module psp_props (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       chipSelN,
    input wire logic       readN,
    input wire logic       writeN,
    input wire logic [7:0] hostData,
    input wire logic       hostDataOe,
    input wire logic       portDataOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    strobe_needs_cs_a: assert property ((!readN || !writeN) |-> !chipSelN)
        else $error("strobe low without chip select");
    strobes_apart_a: assert property (!(!readN && !writeN))
        else $error("read and write strobes low together");
    // the sync plus edge logic needs a minimum low time
    write_len_a: assert property ($fell(writeN) |-> !writeN [*5])
        else $error("write strobe too short");
    write_end_a: assert property ($fell(writeN) |-> ##[5:20] writeN)
        else $error("write strobe never released");
    write_data_a: assert property ((!writeN && $past(!writeN)) |-> hostDataOe && $stable(hostData))
        else $error("write data moved during strobe");
    read_drive_a: assert property ($rose(portDataOe) |-> $past(!chipSelN && !readN, 3))
        else $error("port drive without read access");
    read_release_a: assert property ($fell(portDataOe) |-> $past(readN, 2))
        else $error("port drive dropped inside read");
    write_no_drive_a: assert property (!writeN |-> !portDataOe)
        else $error("port driven during write");
    cover property ($rose(portDataOe));
    cover property ($rose(writeN));
    cover property ($fell(readN));
endmodule : psp_props
`default_nettype wire

// ### tb/test_parallel_slave_port.sv
// self-checking bench: host end drives the slave port end over the pin link
`timescale 1ns/1ps
`default_nettype none
module test_parallel_slave_port;
    logic       clk       = 1'b0;
    logic       rst       = 1'b1;
    logic [2:0] regAddr   = 3'h0;
    logic [7:0] regWrData = 8'h00;
    logic       regWrite  = 1'b0;
    logic       regRead   = 1'b0;
    logic [1:0] cmdAddr   = 2'h0;
    logic [7:0] cmdWrData = 8'h00;
    logic       cmdWrite  = 1'b0;
    logic       cmdRead   = 1'b0;
    logic [7:0] regRdData;
    logic [7:0] cmdRdData;
    logic [7:0] gpioOut;
    logic [7:0] gpioOe;
    logic       irq;
    logic [7:0] rd;
    int         badCount    = 0;
    int         checksDone  = 0;
    psp_bus_if bus ();
    always #5 clk = ~clk;
    psp_device psp_device_inst (.clk(clk), .rst(rst), .bus(bus), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .irq(irq), .gpioOut(gpioOut), .gpioOe(gpioOe));
    psp_host #(.STROBE_LEN(8)) psp_host_inst (.clk(clk), .rst(rst), .bus(bus),
        .cmdAddr(cmdAddr), .cmdWrData(cmdWrData), .cmdWrite(cmdWrite),
        .cmdRead(cmdRead), .cmdRdData(cmdRdData));
    psp_props psp_props_inst (.clk(clk), .rst(rst), .chipSelN(bus.chipSelN),
        .readN(bus.readN), .writeN(bus.writeN), .hostData(bus.hostData),
        .hostDataOe(bus.hostDataOe), .portDataOe(bus.portDataOe));

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : endOfTest

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic devWr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : devWr

    task automatic devRd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask : devRd

    task automatic devChk(input logic [2:0] a, input logic [7:0] exp, input string what);
        logic [7:0] v;
        devRd(a, v);
        check(what, v, exp);
    endtask : devChk

    task automatic hWr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        cmdAddr <= a;
        cmdWrData <= d;
        cmdWrite <= 1'b1;
        @(posedge clk);
        cmdWrite <= 1'b0;
    endtask : hWr

    task automatic hRd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        cmdAddr <= a;
        cmdRead <= 1'b1;
        @(posedge clk);
        cmdRead <= 1'b0;
        #1 d = cmdRdData;
    endtask : hRd

    // one external access; the wait after done covers the device's three-edge flag delay
    task automatic hostOp(input int cmd, input logic [7:0] d);
        int n = 0;
        hWr(psp_pkg::HREG_DATA, d);
        hWr(psp_pkg::HREG_CMD, 8'h01 << cmd);
        rd = 8'h00;
        while (rd[1] !== 1'b1 && n < 40) begin
            hRd(psp_pkg::HREG_STATUS, rd);
            n++;
        end
        if (rd[1] !== 1'b1) begin
            badCount++;
            endOfTest();
        end
        repeat (4) @(posedge clk);
    endtask : hostOp

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        devChk(psp_pkg::REG_CONTROL, 8'h00, "control reset");
        devChk(psp_pkg::REG_DIR_E, 8'hFF, "dirE reset");
        devChk(3'h7, 8'h00, "unmapped");
        devWr(psp_pkg::REG_DIR_D, 8'h0F);
        @(posedge clk);
        #1 check("gpio oe", gpioOe, 8'hF0);
        hostOp(psp_pkg::HCMD_WRITE, 8'hA5);
        devChk(psp_pkg::REG_CONTROL, 8'h00, "mode0 write");
        $display("test general io done");
        devWr(psp_pkg::REG_IRQ_MASK, 8'h80);
        devWr(psp_pkg::REG_CONTROL, 8'h10);
        @(posedge clk);
        #1 check("slave oe", gpioOe, 8'h00);
        hostOp(psp_pkg::HCMD_WRITE, 8'h3C);
        check("irq set", {7'h00, irq}, 8'h01);
        devChk(psp_pkg::REG_CONTROL, 8'h90, "input full");
        devChk(psp_pkg::REG_IRQ_FLAG, 8'h80, "flag set");
        devChk(psp_pkg::REG_IRQ_FLAG, 8'h00, "flag cleared");
        check("irq clear", {7'h00, irq}, 8'h00);
        devChk(psp_pkg::REG_PIN_DATA, 8'h3C, "rx byte");
        devChk(psp_pkg::REG_CONTROL, 8'h10, "full cleared");
        hostOp(psp_pkg::HCMD_WRITE, 8'h11);
        hostOp(psp_pkg::HCMD_WRITE, 8'h22);
        devChk(psp_pkg::REG_CONTROL, 8'hB0, "overflow");
        devWr(psp_pkg::REG_CONTROL, 8'h10);
        devChk(psp_pkg::REG_CONTROL, 8'h90, "overflow cleared");
        devRd(psp_pkg::REG_PIN_DATA, rd);
        $display("test external write done");
        devWr(psp_pkg::REG_IRQ_MASK, 8'h00);
        devChk(psp_pkg::REG_IRQ_FLAG, 8'h80, "write flag");
        devWr(psp_pkg::REG_OUT_LATCH, 8'hC3);
        devChk(psp_pkg::REG_CONTROL, 8'h50, "output full");
        check("gpio out", gpioOut, 8'hC3);
        hostOp(psp_pkg::HCMD_READ, 8'h00);
        hRd(psp_pkg::HREG_DATA, rd);
        check("host rx", rd, 8'hC3);
        check("irq masked", {7'h00, irq}, 8'h00);
        devChk(psp_pkg::REG_CONTROL, 8'h10, "output read");
        devChk(psp_pkg::REG_IRQ_FLAG, 8'h80, "read flag");
        $display("test external read done");
        devWr(psp_pkg::REG_DIR_E, 8'hFB);
        hostOp(psp_pkg::HCMD_WRITE, 8'h77);
        devChk(psp_pkg::REG_CONTROL, 8'h10, "dirE ignore");
        $display("test pin direction done");
        endOfTest();
    end
endmodule : test_parallel_slave_port
`default_nettype wire
